// *** ofs_pkg.sv ***
// Constants and types shared by the output function selector files
`default_nettype none
// ============================================================
// How it works
// - Mask bit 1 sends undervoltage trips to failure
// - Mask bit 2 sends other trips to failure
// - Mask bit 3 flags final restart retry failure
// - Status covers three outputs, six with card
// - Code 0 hands contact to option card
// - Code 1 commanded near output frequency
// - Code 2 command near level, code 1 true
// - Code 3 level near output frequency
// - Code 4 level detect with half-band hysteresis
// - Codes 5 to 12 pass fault flags
// - Code 13 reference or serial command lost
// - Code 14 running with voltage, not braking
// - Code 15 command off and no voltage
// - Code 16 steady speed operation
// - Codes 17, 18 bypass drive and line power
// - Code 19 during speed search
// - Codes 20, 21 pulse on sequence events
// - Code 22 healthy idle awaiting command
// - Codes 23, 24 traverse frequencies reached
// - Code 25 multi-motor, only app mode 3 and the three base outputs
// - Code 26 zero speed in vector control
// - Polarity bit per output, one closes normally, ignored when code 0 selected
// ============================================================
package ofs_pkg;
	localparam int NUM_OUT = 6;
	localparam int NUM_BASE = 3;
	localparam int CODE_W = 5;
	localparam int FREQ_W = 16;
	localparam int SEL_FIELD_W = 8;
	// Register byte offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_POL = 8'h04;
	localparam logic [7:0] REG_SEL_BASE = 8'h08;
	localparam logic [7:0] REG_SEL_EXT = 8'h0c;
	localparam logic [7:0] REG_DETECT = 8'h10;
	localparam logic [7:0] REG_ZERO = 8'h14;
	localparam logic [7:0] REG_STATUS = 8'h18;
	// Control register fields
	localparam int TRIP_MASK_LSB = 0;
	localparam int APP_MODE_LSB = 4;
	localparam int BAND_LSB = 16;
	localparam logic [2:0] TRIP_MASK_RST = 3'h2;
	localparam logic [3:0] APP_MODE_RST = 4'h0;
	localparam logic [3:0] APP_MODE_MMC = 4'h3;
	localparam logic [5:0] POL_RST = 6'h00;
	// Frequencies in units of 0.01 Hz
	localparam logic [FREQ_W-1:0] DETECT_LEVEL_RST = 16'h0bb8;
	localparam logic [FREQ_W-1:0] DETECT_BAND_RST = 16'h03e8;
	localparam logic [FREQ_W-1:0] ZERO_LEVEL_RST = 16'h00c8;
	localparam logic [FREQ_W-1:0] ZERO_BAND_RST = 16'h0064;
	// Selection codes
	typedef logic [CODE_W-1:0] ofs_code_t;
	localparam ofs_code_t C_NONE = 5'h00, C_FDT1 = 5'h01, C_FDT2 = 5'h02;
	localparam ofs_code_t C_FDT3 = 5'h03, C_FDT4 = 5'h04, C_MOL = 5'h05;
	localparam ofs_code_t C_DOL = 5'h06, C_ULD = 5'h07, C_FAN = 5'h08;
	localparam ofs_code_t C_STALL = 5'h09, C_OVV = 5'h0a, C_UNV = 5'h0b;
	localparam ofs_code_t C_HEAT = 5'h0c, C_LOST = 5'h0d, C_RUN = 5'h0e;
	localparam ofs_code_t C_STOP = 5'h0f, C_STEADY = 5'h10, C_DRV = 5'h11;
	localparam ofs_code_t C_LINE = 5'h12, C_SRCH = 5'h13, C_STEP = 5'h14;
	localparam ofs_code_t C_SEQ = 5'h15, C_READY = 5'h16, C_TACC = 5'h17;
	localparam ofs_code_t C_TDEC = 5'h18, C_MMC = 5'h19, C_ZSPD = 5'h1a;
	localparam ofs_code_t C_TRIP = 5'h1c;
	// Reset codes, output 0 in the low field
	localparam logic [CODE_W*NUM_OUT-1:0] SEL_RST =
		{C_NONE, C_NONE, C_NONE, C_FDT1, C_RUN, C_TRIP};
endpackage
`default_nettype wire

// *** ofs_freq_if.sv ***
// Interface between the selector and its frequency detector
`default_nettype none
interface ofs_freq_if;
	logic [15:0] cmd_freq;
	logic [15:0] out_freq;
	logic [15:0] detect_level;
	logic [15:0] detect_band;
	logic [15:0] zero_speed_level;
	logic [15:0] zero_speed_band;
	logic vector_mode;
	logic fdt1;
	logic fdt2;
	logic fdt3;
	logic fdt4;
	logic zspd;
	modport src (output cmd_freq, out_freq, detect_level, detect_band,
		zero_speed_level, zero_speed_band, vector_mode,
		input fdt1, fdt2, fdt3, fdt4, zspd);
	modport det (input cmd_freq, out_freq, detect_level, detect_band,
		zero_speed_level, zero_speed_band, vector_mode,
		output fdt1, fdt2, fdt3, fdt4, zspd);
endinterface
`default_nettype wire

// *** ofs_freq_det.sv ***
// Frequency detection comparators on registered frequency values
`default_nettype none
module ofs_freq_det
	import ofs_pkg::*;
(
	input wire logic clk_i,
	input wire logic resetn_i,
	ofs_freq_if.det fq
);
	logic [FREQ_W-1:0] cmd_q;
	logic [FREQ_W-1:0] out_q;
	logic [FREQ_W:0] dist_co;
	logic [FREQ_W:0] dist_cl;
	logic [FREQ_W:0] dist_lo;
	logic [FREQ_W+1:0] dec_lhs;
	logic near_co;

	// Twice the distance, compared against the band
	function automatic logic [FREQ_W:0] twodist(
		input logic [FREQ_W-1:0] a, input logic [FREQ_W-1:0] b);
		logic [FREQ_W-1:0] d;
		d = (a > b) ? a - b : b - a;
		return {d, 1'b0};
	endfunction

	// ============================================================
	// Registered frequencies
	always_ff @(posedge clk_i)
	begin
		if (!resetn_i)
		begin
			cmd_q <= 16'h0000;
			out_q <= 16'h0000;
		end
		else
		begin
			cmd_q <= fq.cmd_freq;
			out_q <= fq.out_freq;
		end
	end

	always_comb
	begin
		dist_co = twodist(cmd_q, out_q);
		dist_cl = twodist(cmd_q, fq.detect_level);
		dist_lo = twodist(fq.detect_level, out_q);
		dec_lhs = {1'b0, out_q, 1'b0} + {2'b00, fq.detect_band};
		near_co = dist_co < {1'b0, fq.detect_band};
	end

	// ============================================================
	// Detection flags
	always_ff @(posedge clk_i)
	begin
		if (!resetn_i)
		begin
			fq.fdt1 <= 1'b0;
			fq.fdt2 <= 1'b0;
			fq.fdt3 <= 1'b0;
			fq.zspd <= 1'b0;
		end
		else
		begin
			fq.fdt1 <= near_co;
			fq.fdt2 <= near_co && (dist_cl < {1'b0, fq.detect_band});
			fq.fdt3 <= dist_lo < {1'b0, fq.detect_band};
			fq.zspd <= fq.vector_mode && ({1'b0, out_q, 1'b0} <
				{1'b0, fq.zero_speed_level, 1'b0} +
				{2'b00, fq.zero_speed_band});
		end
	end

	// Level detect, rises at level, falls at or below level less half band
	always_ff @(posedge clk_i)
	begin
		if (!resetn_i)
			fq.fdt4 <= 1'b0;
		else if (out_q >= fq.detect_level)
			fq.fdt4 <= 1'b1;
		else if (dec_lhs <= {1'b0, fq.detect_level, 1'b0})
			fq.fdt4 <= 1'b0;
	end

	property p_fdt1;
		@(posedge clk_i) disable iff (!resetn_i)
		(cmd_q == out_q && fq.detect_band != 16'h0000) |=> fq.fdt1;
	endproperty
	a_fdt1: assert property (p_fdt1) else $error("fdt1 missed match");

	property p_fdt2;
		@(posedge clk_i) disable iff (!resetn_i)
		fq.fdt2 |-> fq.fdt1;
	endproperty
	a_fdt2: assert property (p_fdt2) else $error("fdt2 without fdt1");

	property p_fdt4;
		@(posedge clk_i) disable iff (!resetn_i)
		(out_q >= fq.detect_level) |=> fq.fdt4;
	endproperty
	a_fdt4: assert property (p_fdt4) else $error("fdt4 not set");
endmodule
`default_nettype wire

// *** ofs_top.sv ***
// Output function selector with Avalon-MM register slave
`default_nettype none
module ofs_top
	import ofs_pkg::*;
(
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic [7:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	input wire logic [15:0] cmd_freq_i,
	input wire logic [15:0] out_freq_i,
	input wire logic vector_mode_i,
	input wire logic ext_card_i,
	input wire logic trip_i,
	input wire logic trip_undervolt_i,
	input wire logic restart_final_fail_i,
	input wire logic motor_overload_i,
	input wire logic drive_overload_flag_i,
	input wire logic underload_i,
	input wire logic fan_fault_i,
	input wire logic stall_i,
	input wire logic dc_overvolt_i,
	input wire logic dc_undervolt_i,
	input wire logic overheat_i,
	input wire logic ref_lost_i,
	input wire logic run_cmd_i,
	input wire logic volt_out_i,
	input wire logic dc_brake_i,
	input wire logic accel_i,
	input wire logic decel_i,
	input wire logic bypass_drive_i,
	input wire logic bypass_line_i,
	input wire logic speed_search_i,
	input wire logic step_adv_i,
	input wire logic seq_done_i,
	input wire logic healthy_i,
	input wire logic traverse_accel_reached_i,
	input wire logic traverse_decel_reached_i,
	input wire logic [2:0] mmc_drive_i,
	input wire logic [5:0] plc_drive_i,
	output logic [4:0] relay_o,
	output logic transistor_output_o
);
	logic [2:0] trip_mask_q;
	logic [3:0] app_mode_q;
	logic [NUM_OUT-1:0] pol_q;
	ofs_code_t sel_q [NUM_OUT];
	logic [FREQ_W-1:0] detect_level_q;
	logic [FREQ_W-1:0] detect_band_q;
	logic [FREQ_W-1:0] zero_level_q;
	logic [FREQ_W-1:0] zero_band_q;
	logic [NUM_OUT-1:0] drive_q;
	logic fail_q;
	logic [31:0] cond;
	logic [31:0] next_readdata;
	logic [31:0] sel_base_view;
	logic [31:0] sel_ext_view;
	logic [31:0] ctrl_view;
	logic wr_en;
	wire logic [NUM_OUT-1:0] next_drive;
	wire logic [NUM_OUT-1:0] mmc_vec;

	ofs_freq_if fq ();

	// Byte-lane merge of write data into a register view
	function automatic logic [31:0] wmerge(input logic [31:0] old,
		input logic [31:0] wd, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++)
		begin
			if (be[b])
				r[b*8 +: 8] = wd[b*8 +: 8];
		end
		return r;
	endfunction

	// ============================================================
	// Avalon-MM slave, one wait cycle per access
	always_ff @(posedge clk_i)
	begin
		if (!resetn_i)
			avs_waitrequest_o <= 1'b1;
		else if (!avs_waitrequest_o)
			avs_waitrequest_o <= 1'b1;
		else if (avs_read_i || avs_write_i)
			avs_waitrequest_o <= 1'b0;
	end

	// Write lands on the edge that sees waitrequest low
	assign wr_en = avs_write_i && !avs_waitrequest_o;

	// Register views for read and byte-lane merge
	always_comb
	begin
		ctrl_view = 32'h0000_0000;
		ctrl_view[TRIP_MASK_LSB +: 3] = trip_mask_q;
		ctrl_view[APP_MODE_LSB +: 4] = app_mode_q;
		sel_base_view = 32'h0000_0000;
		sel_ext_view = 32'h0000_0000;
		for (int k = 0; k < NUM_BASE; k++)
		begin
			sel_base_view[k*SEL_FIELD_W +: CODE_W] = sel_q[k];
			sel_ext_view[k*SEL_FIELD_W +: CODE_W] = sel_q[k+NUM_BASE];
		end
	end

	// Read data mux, unmapped addresses read zero
	always_comb
	begin
		case (avs_address_i)
			REG_CTRL: next_readdata = ctrl_view;
			REG_POL: next_readdata = {26'h000_0000, pol_q};
			REG_SEL_BASE: next_readdata = sel_base_view;
			REG_SEL_EXT: next_readdata = sel_ext_view;
			REG_DETECT: next_readdata = {detect_band_q, detect_level_q};
			REG_ZERO: next_readdata = {zero_band_q, zero_level_q};
			REG_STATUS: next_readdata = {26'h000_0000, drive_q};
			default: next_readdata = 32'h0000_0000;
		endcase
	end

	// Read data captured as waitrequest drops
	always_ff @(posedge clk_i)
	begin
		if (!resetn_i)
			avs_readdata_o <= 32'h0000_0000;
		else if (avs_read_i && avs_waitrequest_o)
			avs_readdata_o <= next_readdata;
	end

	// ============================================================
	// Control, polarity and frequency parameter registers
	always_ff @(posedge clk_i)
	begin
		logic [31:0] m;
		m = wmerge(ctrl_view, avs_writedata_i, avs_byteenable_i);
		if (!resetn_i)
		begin
			trip_mask_q <= TRIP_MASK_RST;
			app_mode_q <= APP_MODE_RST;
		end
		else if (wr_en && avs_address_i == REG_CTRL)
		begin
			trip_mask_q <= m[TRIP_MASK_LSB +: 3];
			app_mode_q <= m[APP_MODE_LSB +: 4];
		end
	end

	always_ff @(posedge clk_i)
	begin
		logic [31:0] m;
		m = wmerge({26'h000_0000, pol_q}, avs_writedata_i,
			avs_byteenable_i);
		if (!resetn_i)
			pol_q <= POL_RST;
		else if (wr_en && avs_address_i == REG_POL)
			pol_q <= m[NUM_OUT-1:0];
	end

	always_ff @(posedge clk_i)
	begin
		logic [31:0] m;
		m = wmerge({detect_band_q, detect_level_q}, avs_writedata_i,
			avs_byteenable_i);
		if (!resetn_i)
		begin
			detect_level_q <= DETECT_LEVEL_RST;
			detect_band_q <= DETECT_BAND_RST;
		end
		else if (wr_en && avs_address_i == REG_DETECT)
		begin
			detect_level_q <= m[FREQ_W-1:0];
			detect_band_q <= m[BAND_LSB +: FREQ_W];
		end
	end

	always_ff @(posedge clk_i)
	begin
		logic [31:0] m;
		m = wmerge({zero_band_q, zero_level_q}, avs_writedata_i,
			avs_byteenable_i);
		if (!resetn_i)
		begin
			zero_level_q <= ZERO_LEVEL_RST;
			zero_band_q <= ZERO_BAND_RST;
		end
		else if (wr_en && avs_address_i == REG_ZERO)
		begin
			zero_level_q <= m[FREQ_W-1:0];
			zero_band_q <= m[BAND_LSB +: FREQ_W];
		end
	end

	// Selection code per output
	always_ff @(posedge clk_i)
	begin
		logic [31:0] mb;
		logic [31:0] me;
		mb = wmerge(sel_base_view, avs_writedata_i, avs_byteenable_i);
		me = wmerge(sel_ext_view, avs_writedata_i, avs_byteenable_i);
		if (!resetn_i)
		begin
			for (int k = 0; k < NUM_OUT; k++)
				sel_q[k] <= SEL_RST[k*CODE_W +: CODE_W];
		end
		else if (wr_en && avs_address_i == REG_SEL_BASE)
		begin
			for (int k = 0; k < NUM_BASE; k++)
				sel_q[k] <= mb[k*SEL_FIELD_W +: CODE_W];
		end
		else if (wr_en && avs_address_i == REG_SEL_EXT)
		begin
			for (int k = 0; k < NUM_BASE; k++)
				sel_q[k+NUM_BASE] <= me[k*SEL_FIELD_W +: CODE_W];
		end
	end

	// ============================================================
	// Frequency detector
	assign fq.cmd_freq = cmd_freq_i;
	assign fq.out_freq = out_freq_i;
	assign fq.detect_level = detect_level_q;
	assign fq.detect_band = detect_band_q;
	assign fq.zero_speed_level = zero_level_q;
	assign fq.zero_speed_band = zero_band_q;
	assign fq.vector_mode = vector_mode_i;

	ofs_freq_det u_det (
		.clk_i(clk_i),
		.resetn_i(resetn_i),
		.fq(fq.det)
	);

	// Failure output from the trip mask
	always_ff @(posedge clk_i)
	begin
		if (!resetn_i)
			fail_q <= 1'b0;
		else
			fail_q <= (trip_mask_q[0] && trip_i && trip_undervolt_i)
				|| (trip_mask_q[1] && trip_i && !trip_undervolt_i)
				|| (trip_mask_q[2] && restart_final_fail_i);
	end

	// ============================================================
	// Condition vector indexed by selection code
	always_comb
	begin
		cond = 32'h0000_0000;
		cond[C_FDT1] = fq.fdt1;
		cond[C_FDT2] = fq.fdt2;
		cond[C_FDT3] = fq.fdt3;
		cond[C_FDT4] = fq.fdt4;
		cond[C_MOL] = motor_overload_i;
		cond[C_DOL] = drive_overload_flag_i;
		cond[C_ULD] = underload_i;
		cond[C_FAN] = fan_fault_i;
		cond[C_STALL] = stall_i;
		cond[C_OVV] = dc_overvolt_i;
		cond[C_UNV] = dc_undervolt_i;
		cond[C_HEAT] = overheat_i;
		cond[C_LOST] = ref_lost_i;
		cond[C_RUN] = run_cmd_i && volt_out_i && !dc_brake_i;
		cond[C_STOP] = !run_cmd_i && !volt_out_i;
		cond[C_STEADY] = volt_out_i && !accel_i && !decel_i;
		cond[C_DRV] = bypass_drive_i;
		cond[C_LINE] = bypass_line_i;
		cond[C_SRCH] = speed_search_i;
		cond[C_STEP] = step_adv_i;
		cond[C_SEQ] = seq_done_i;
		cond[C_READY] = healthy_i && !run_cmd_i;
		cond[C_TACC] = traverse_accel_reached_i;
		cond[C_TDEC] = traverse_decel_reached_i;
		cond[C_ZSPD] = fq.zspd;
		cond[C_TRIP] = fail_q;
	end

	assign mmc_vec = {3'h0, mmc_drive_i};

	// Per-output multiplexer, polarity and card presence
	genvar gi;
	generate
		for (gi = 0; gi < NUM_OUT; gi++)
		begin : g_out
			logic raw;
			logic live;
			always_comb
			begin
				live = (gi < NUM_BASE) || ext_card_i;
				if (sel_q[gi] == C_MMC)
					raw = (gi < NUM_BASE) && app_mode_q == APP_MODE_MMC
						&& mmc_vec[gi];
				else
					raw = cond[sel_q[gi]];
			end
			assign next_drive[gi] = !live ? 1'b0 :
				(sel_q[gi] == C_NONE) ? plc_drive_i[gi] :
				raw ^ pol_q[gi];
		end
	endgenerate

	// Final levels, also the status word
	always_ff @(posedge clk_i)
	begin
		if (!resetn_i)
			drive_q <= 6'h00;
		else
			drive_q <= next_drive;
	end

	assign relay_o = {drive_q[5:3], drive_q[1:0]};
	assign transistor_output_o = drive_q[2];

	// ============================================================
	// Checks
	property p_fail_uv;
		@(posedge clk_i) disable iff (!resetn_i)
		(trip_mask_q[0] && trip_i && trip_undervolt_i) |=> fail_q;
	endproperty
	a_fail_uv: assert property (p_fail_uv) else $error("uv trip lost");

	property p_fail_other;
		@(posedge clk_i) disable iff (!resetn_i)
		(trip_i && !trip_undervolt_i && !restart_final_fail_i)
			|=> (fail_q == $past(trip_mask_q[1]));
	endproperty
	a_fail_other: assert property (p_fail_other) else $error("trip bad");

	property p_fail_retry;
		@(posedge clk_i) disable iff (!resetn_i)
		(!trip_i && restart_final_fail_i)
			|=> (fail_q == $past(trip_mask_q[2]));
	endproperty
	a_fail_retry: assert property (p_fail_retry) else $error("retry bad");

	property p_ext_off;
		@(posedge clk_i) disable iff (!resetn_i)
		!ext_card_i |=> (relay_o[4:2] == 3'h0);
	endproperty
	a_ext_off: assert property (p_ext_off) else $error("ext relay on");

	property p_none;
		@(posedge clk_i) disable iff (!resetn_i)
		(sel_q[1] == C_NONE) |=> (relay_o[1] == $past(plc_drive_i[1]));
	endproperty
	a_none: assert property (p_none) else $error("code 0 not passed");

	property p_run_brake;
		@(posedge clk_i) disable iff (!resetn_i)
		(sel_q[1] == C_RUN && !pol_q[1] && dc_brake_i) |=> !relay_o[1];
	endproperty
	a_run_brake: assert property (p_run_brake) else $error("run in brake");

	property p_stop_nc;
		@(posedge clk_i) disable iff (!resetn_i)
		(sel_q[1] == C_STOP && pol_q[1] && !run_cmd_i && !volt_out_i)
			|=> !relay_o[1];
	endproperty
	a_stop_nc: assert property (p_stop_nc) else $error("nc stop wrong");

	property p_mmc;
		@(posedge clk_i) disable iff (!resetn_i)
		(sel_q[1] == C_MMC && app_mode_q != APP_MODE_MMC && !pol_q[1])
			|=> !relay_o[1];
	endproperty
	a_mmc: assert property (p_mmc) else $error("mmc outside mode");

	property p_status;
		@(posedge clk_i) disable iff (!resetn_i)
		(avs_read_i && avs_waitrequest_o && avs_address_i == REG_STATUS)
			|=> (avs_readdata_o[5:0] == $past(drive_q)) && !avs_waitrequest_o;
	endproperty
	a_status: assert property (p_status) else $error("status bad");
endmodule
`default_nettype wire

// *** ofs_contactors.sv ***
// Bypass contactor pair switched by two selector outputs
`default_nettype none
module ofs_contactors
#(
	parameter int DELAY = 3
)
(
	input wire logic clk_i,
	input wire logic drive_coil_i,
	input wire logic line_coil_i,
	output logic drive_closed_o,
	output logic line_closed_o,
	output logic overlap_o
);
	logic [DELAY-1:0] drv_sh = '0;
	logic [DELAY-1:0] line_sh = '0;
	logic ovl = 1'b0;
	// ============================================================
	// Mechanical pickup and dropout delay of each contactor
	always_ff @(posedge clk_i)
	begin
		drv_sh <= {drv_sh[DELAY-2:0], drive_coil_i};
		line_sh <= {line_sh[DELAY-2:0], line_coil_i};
	end
	assign drive_closed_o = drv_sh[DELAY-1];
	assign line_closed_o = line_sh[DELAY-1];
	// Sticky flag, both closed would tie line to drive output
	always_ff @(posedge clk_i)
	begin
		ovl <= ovl | (drive_closed_o === 1'b1 && line_closed_o === 1'b1);
	end
	assign overlap_o = ovl;
endmodule
`default_nettype wire

// *** output_function_selector_bench.sv ***
// Self-checking bench for the output function selector
`default_nettype none
`define CHK(nm, e, g) check_val(nm, 32'(e), 32'(g))
module output_function_selector_bench
	import ofs_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct packed
	{
		ofs_code_t code;
		logic [25:0] st;
		logic [15:0] cf;
		logic [15:0] oq;
		logic exp;
	} ofs_row_t;
	localparam logic [15:0] Z = 16'h0000;
	logic clk_i = 1'b0;
	logic resetn_i = 1'b0;
	logic [7:0] addr = 8'h00;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [31:0] wdata = 32'h0000_0000;
	logic [3:0] ben = 4'hf;
	logic [25:0] st = 26'h000_0000;
	logic [15:0] cf = 16'h0000;
	logic [15:0] oq = 16'h0000;
	logic ext = 1'b0;
	logic [2:0] mmc = 3'h0;
	logic [5:0] plc = 6'h00;
	logic [31:0] rdata;
	logic wait_req;
	logic [4:0] relay;
	logic trans;
	logic drv_closed;
	logic line_closed;
	logic overlap;
	logic [31:0] got;
	int n_errors = 0;
	int n_compared = 0;
	int i;
	logic [7:0] ra [7] = '{REG_CTRL, REG_POL, REG_SEL_BASE, REG_SEL_EXT,
		REG_DETECT, REG_ZERO, 8'h40};
	logic [31:0] rv [7] = '{32'h0000_0002, 32'h0000_0000, 32'h0001_0e1c,
		32'h0000_0000, 32'h03e8_0bb8, 32'h0064_00c8, 32'h0000_0000};
	// ============================================================
	// Rows: code on relay 2, status bits, frequencies, expected level
	ofs_row_t rows [31] = '{
		'{C_RUN, 26'h000_0600, Z, Z, 1'b1},
		'{C_RUN, 26'h000_0e00, Z, Z, 1'b0},
		'{C_RUN, 26'h000_0200, Z, Z, 1'b0},
		'{C_STOP, 26'h000_0000, Z, Z, 1'b1},
		'{C_STOP, 26'h000_0400, Z, Z, 1'b0},
		'{C_STEADY, 26'h000_0400, Z, Z, 1'b1},
		'{C_STEADY, 26'h000_1400, Z, Z, 1'b0},
		'{C_LINE, 26'h000_8000, Z, Z, 1'b1},
		'{C_SRCH, 26'h001_0000, Z, Z, 1'b1},
		'{C_STEP, 26'h002_0000, Z, Z, 1'b1},
		'{C_SEQ, 26'h004_0000, Z, Z, 1'b1},
		'{C_READY, 26'h008_0000, Z, Z, 1'b1},
		'{C_READY, 26'h008_0200, Z, Z, 1'b0},
		'{C_TACC, 26'h010_0000, Z, Z, 1'b1},
		'{C_TDEC, 26'h020_0000, Z, Z, 1'b1},
		'{C_TRIP, 26'h040_0000, Z, Z, 1'b1},
		'{C_TRIP, 26'h0c0_0000, Z, Z, 1'b0},
		'{C_FDT1, 26'h000_0000, 16'h0bb8, 16'h09c5, 1'b1},
		'{C_FDT1, 26'h000_0000, 16'h0bb8, 16'h09c4, 1'b0},
		'{C_FDT2, 26'h000_0000, 16'h0dab, 16'h0dab, 1'b1},
		'{C_FDT2, 26'h000_0000, 16'h0dac, 16'h0dac, 1'b0},
		'{C_FDT2, 26'h000_0000, 16'h0dab, 16'h0bb7, 1'b0},
		'{C_FDT3, 26'h000_0000, Z, 16'h09c5, 1'b1},
		'{C_FDT3, 26'h000_0000, Z, 16'h0dac, 1'b0},
		'{C_FDT4, 26'h000_0000, Z, 16'h0bb8, 1'b1},
		'{C_FDT4, 26'h000_0000, Z, 16'h09c5, 1'b1},
		'{C_FDT4, 26'h000_0000, Z, 16'h09c4, 1'b0},
		'{C_FDT4, 26'h000_0000, Z, 16'h0bb7, 1'b0},
		'{C_ZSPD, 26'h200_0000, Z, 16'h00f9, 1'b1},
		'{C_ZSPD, 26'h200_0000, Z, 16'h00fa, 1'b0},
		'{C_ZSPD, 26'h000_0000, Z, 16'h0000, 1'b0}
	};
	// Clock
	always #5 clk_i = ~clk_i;
	// ============================================================
	// Design and contactor model
	ofs_top dut
	(
		.clk_i(clk_i), .resetn_i(resetn_i),
		.avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr),
		.avs_writedata_i(wdata), .avs_byteenable_i(ben),
		.avs_readdata_o(rdata), .avs_waitrequest_o(wait_req),
		.cmd_freq_i(cf), .out_freq_i(oq), .vector_mode_i(st[25]),
		.ext_card_i(ext), .trip_i(st[22]), .trip_undervolt_i(st[23]),
		.restart_final_fail_i(st[24]), .motor_overload_i(st[0]),
		.drive_overload_flag_i(st[1]), .underload_i(st[2]),
		.fan_fault_i(st[3]), .stall_i(st[4]), .dc_overvolt_i(st[5]),
		.dc_undervolt_i(st[6]), .overheat_i(st[7]), .ref_lost_i(st[8]),
		.run_cmd_i(st[9]), .volt_out_i(st[10]), .dc_brake_i(st[11]),
		.accel_i(st[12]), .decel_i(st[13]), .bypass_drive_i(st[14]),
		.bypass_line_i(st[15]), .speed_search_i(st[16]),
		.step_adv_i(st[17]), .seq_done_i(st[18]), .healthy_i(st[19]),
		.traverse_accel_reached_i(st[20]),
		.traverse_decel_reached_i(st[21]),
		.mmc_drive_i(mmc), .plc_drive_i(plc),
		.relay_o(relay), .transistor_output_o(trans)
	);
	ofs_contactors #(.DELAY(3)) bypass
	(
		.clk_i(clk_i), .drive_coil_i(relay[2]), .line_coil_i(relay[3]),
		.drive_closed_o(drv_closed), .line_closed_o(line_closed),
		.overlap_o(overlap)
	);
	// ============================================================
	// Verdict and comparison
	task automatic tally_and_finish();
		$display("errors %0d compared %0d", n_errors, n_compared);
		if (n_errors == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic check_val(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		n_compared++;
		if (g !== e)
		begin
			n_errors++;
			$display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
		end
	endtask
	// One bus access, held until waitrequest is sampled low
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d, input logic [3:0] be);
		int n;
		@(posedge clk_i);
		addr <= a;
		wdata <= d;
		ben <= be;
		rd <= !w;
		wr <= w;
		for (n = 0; n < 20; n++)
		begin
			@(posedge clk_i);
			if (wait_req === 1'b0)
				break;
		end
		got = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
		if (n == 20)
		begin
			n_errors++;
			tally_and_finish();
		end
	endtask
	// Select a code on relay 2, apply inputs, compare after latency
	task automatic run_row(input ofs_row_t r);
		bus(1'b1, REG_SEL_BASE, {19'h0_0000, r.code, 8'h00}, 4'b0010);
		st <= r.st;
		cf <= r.cf;
		oq <= r.oq;
		repeat (5) @(posedge clk_i);
		`CHK("relay2", r.exp, relay[1]);
	endtask
	// ============================================================
	// Main sequence
	initial
	begin
		repeat (3) @(posedge clk_i);
		`CHK("relay at reset", 5'h00, relay);
		resetn_i <= 1'b1;
		for (i = 0; i < 7; i++)
		begin
			bus(1'b0, ra[i], 32'h0000_0000, 4'hf);
			`CHK("reset value", rv[i], got);
		end
		bus(1'b1, 8'h40, 32'hffff_ffff, 4'hf);
		bus(1'b0, 8'h40, 32'h0000_0000, 4'hf);
		`CHK("unmapped", 32'h0000_0000, got);
		for (i = 0; i < 9; i++)
			run_row(ofs_row_t'{ofs_code_t'(5 + i), 26'(1 << i), Z, Z, 1'b1});
		for (i = 0; i < 31; i++)
			run_row(rows[i]);
		bus(1'b1, REG_CTRL, 32'h0000_0001, 4'h1);
		run_row(ofs_row_t'{C_TRIP, 26'h0c0_0000, Z, Z, 1'b1});
		run_row(ofs_row_t'{C_TRIP, 26'h040_0000, Z, Z, 1'b0});
		bus(1'b1, REG_CTRL, 32'h0000_0004, 4'h1);
		run_row(ofs_row_t'{C_TRIP, 26'h100_0000, Z, Z, 1'b1});
		run_row(ofs_row_t'{C_TRIP, 26'h0c0_0000, Z, Z, 1'b0});
		bus(1'b1, REG_POL, 32'h0000_0002, 4'h1);
		run_row(ofs_row_t'{C_STOP, 26'h000_0000, Z, Z, 1'b0});
		run_row(ofs_row_t'{C_RUN, 26'h000_0000, Z, Z, 1'b1});
		plc <= 6'h02;
		run_row(ofs_row_t'{C_NONE, 26'h000_0000, Z, Z, 1'b1});
		plc <= 6'h00;
		run_row(ofs_row_t'{C_NONE, 26'h000_0000, Z, Z, 1'b0});
		bus(1'b1, REG_POL, 32'h0000_0000, 4'h1);
		mmc <= 3'h2;
		bus(1'b1, REG_CTRL, 32'h0000_0032, 4'h1);
		run_row(ofs_row_t'{C_MMC, 26'h000_0000, Z, Z, 1'b1});
		bus(1'b1, REG_CTRL, 32'h0000_0002, 4'h1);
		run_row(ofs_row_t'{C_MMC, 26'h000_0000, Z, Z, 1'b0});
		// Extension relays: relay3 drive path, relay4 line path
		bus(1'b1, REG_SEL_EXT, 32'h0000_1211, 4'hf);
		run_row(ofs_row_t'{C_DRV, 26'h000_4000, Z, Z, 1'b1});
		`CHK("ext off", 3'h0, relay[4:2]);
		ext <= 1'b1;
		repeat (5) @(posedge clk_i);
		`CHK("ext on", 3'h1, relay[4:2]);
		bus(1'b0, REG_STATUS, 32'h0000_0000, 4'hf);
		`CHK("status", 6'h0e, got[5:0]);
		`CHK("drive contact", 1'b1, drv_closed);
		st <= 26'h000_8000;
		repeat (8) @(posedge clk_i);
		`CHK("line path", 2'h2, relay[3:2]);
		`CHK("line contact", 1'b1, line_closed);
		`CHK("no overlap", 1'b0, overlap);
		// Band write on the upper lanes only, then a wider match
		bus(1'b1, REG_DETECT, 32'h07d0_ffff, 4'b1100);
		bus(1'b0, REG_DETECT, 32'h0000_0000, 4'hf);
		`CHK("band write", 32'h07d0_0bb8, got);
		run_row(ofs_row_t'{C_FDT1, 26'h000_0000, 16'h0bb8, 16'h07d1,
			1'b1});
		// Mid-run reset clears outputs and returns written registers to reset values
		resetn_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		`CHK("relay in reset", 5'h00, relay);
		`CHK("transistor in reset", 1'b0, trans);
		resetn_i <= 1'b1;
		@(posedge clk_i);
		`CHK("wait after reset", 1'b1, wait_req);
		`CHK("relay after reset", 5'h00, relay);
		bus(1'b0, REG_SEL_EXT, 32'h0000_0000, 4'hf);
		`CHK("sel ext after reset", 32'h0000_0000, got);
		bus(1'b0, REG_DETECT, 32'h0000_0000, 4'hf);
		`CHK("detect after reset", 32'h03e8_0bb8, got);
		tally_and_finish();
	end
	// Hang guard
	initial
	begin
		repeat (50000) @(posedge clk_i);
		n_errors++;
		tally_and_finish();
	end
endmodule
`undef CHK
`default_nettype wire
